// ===== mpk_defines.svh
`ifndef MPK_DEFINES_SVH
`define MPK_DEFINES_SVH

// Timebase
`define MPK_CLK_PERIOD_NS   25
`define MPK_MS_NS           1000000

// Press and sequence durations in ms
`define MPK_ON_PRESS_MS     16'd1600
`define MPK_OFF_PRESS_MS    16'd2100
`define MPK_RST_PRESS_MS    16'd2100
`define MPK_SHUTDOWN_MS     16'd6000
`define MPK_RESET_HOLD_MS   16'd10
`define MPK_MS_MAX          16'hffff

// Indicator phase lengths in ms
`define MPK_BLINK_SLOW_MS   16'd600
`define MPK_BLINK_LONG_MS   16'd3000
`define MPK_BLINK_FAST_MS   16'd75

// Register byte offsets
`define MPK_CTRL_OFS        8'h00
`define MPK_MODE_OFS        8'h04
`define MPK_STATUS_OFS      8'h08
`define MPK_INT_STAT_OFS    8'h0c
`define MPK_INT_CLR_OFS     8'h10
`define MPK_INT_EN_OFS      8'h14

// Control register fields
`define MPK_CTRL_POWEROFF   0
`define MPK_CTRL_RESET      1
`define MPK_CTRL_ROUTE_LSB  4
`define MPK_CTRL_HOTPLUG    6
`define MPK_CTRL_POLARITY   7

// Status register fields
`define MPK_STAT_PWR_LSB    0
`define MPK_STAT_SUPPLY     2
`define MPK_STAT_CARD       3
`define MPK_STAT_SOFTOFF    4
`define MPK_STAT_HELD_LSB   16

// Interrupt event bits
`define MPK_EV_POWERED_ON   0
`define MPK_EV_SHUTDOWN     1
`define MPK_EV_POWERED_OFF  2
`define MPK_EV_RESET        3
`define MPK_EV_CARD_IN      4
`define MPK_EV_CARD_OUT     5
`define MPK_EV_W            6

// Reset values
`define MPK_HOTPLUG_RST     1'b1
`define MPK_POLARITY_RST    1'b1
`define MPK_ROUTE_RST       2'h0
`define MPK_MODE_RST        3'h0
`define MPK_INT_EN_RST      6'h00

`endif

// ===== mpk_pkg.sv
package mpk_pkg;

  typedef enum logic [1:0] {
    PWR_OFF      = 2'b00,
    PWR_ON       = 2'b01,
    PWR_SHUTDOWN = 2'b10,
    PWR_RESET    = 2'b11
  } mpk_pwr_type;

  typedef enum logic [2:0] {
    IND_DARK    = 3'b000,
    IND_SEARCH  = 3'b001,
    IND_STANDBY = 3'b010,
    IND_DATA    = 3'b011,
    IND_CALL    = 3'b100,
    IND_SLEEP   = 3'b101
  } mpk_ind_type;

  typedef enum logic [1:0] {
    ROUTE_NET = 2'b00,
    ROUTE_ALT = 2'b01,
    ROUTE_AUX = 2'b10
  } mpk_route_type;

endpackage : mpk_pkg

// ===== mpk_press_timer.sv
`timescale 1ns/1ps
`include "mpk_defines.svh"

module mpk_press_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Timebase
  input  wire logic        ms_tick,
  // Control pin, active low
  input  wire logic        pin_n,
  // Measurement
  output logic             fall_pulse,
  output logic             release_pulse,
  output logic [15:0]      held_ms_q
);
  import mpk_pkg::*;

  logic pin_prev_q;

  assign fall_pulse    = pin_prev_q & ~pin_n;
  assign release_pulse = ~pin_prev_q & pin_n;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b1;
    end else if (ce) begin
      pin_prev_q <= pin_n;
    end
  end

  // Count stays readable after release so the caller can judge it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_ms_q <= 16'h0000;
    end else if (ce) begin
      if (fall_pulse) begin
        held_ms_q <= 16'h0000;
      end else if (!pin_n && ms_tick && held_ms_q != `MPK_MS_MAX) begin
        held_ms_q <= held_ms_q + 16'h0001;
      end
    end
  end

endmodule : mpk_press_timer

// ===== mpk_blink.sv
`timescale 1ns/1ps
`include "mpk_defines.svh"

module mpk_blink (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Timebase and mode
  input  wire logic                 ms_tick,
  input  wire mpk_pkg::mpk_ind_type mode,
  // Waveform
  output logic                      wave_q
);
  import mpk_pkg::*;

  mpk_ind_type mode_q;
  logic        high_q;
  logic [15:0] cnt_q;

  function automatic logic [15:0] phase_len(input mpk_ind_type m, input logic hi);
    unique case (m)
      IND_SEARCH:  phase_len = `MPK_BLINK_SLOW_MS;
      IND_STANDBY: phase_len = hi ? `MPK_BLINK_LONG_MS : `MPK_BLINK_FAST_MS;
      IND_DATA:    phase_len = `MPK_BLINK_FAST_MS;
      default:     phase_len = `MPK_MS_MAX;
    endcase
  endfunction : phase_len

  // New mode restarts on a high phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_q <= IND_DARK;
      high_q <= 1'b1;
      cnt_q  <= 16'h0000;
    end else if (ce) begin
      if (mode != mode_q) begin
        mode_q <= mode;
        high_q <= 1'b1;
        cnt_q  <= 16'h0000;
      end else if (ms_tick) begin
        if (cnt_q + 16'h0001 >= phase_len(mode_q, high_q)) begin
          cnt_q  <= 16'h0000;
          high_q <= ~high_q;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wave_q <= 1'b0;
    end else if (ce) begin
      unique case (mode_q)
        IND_SEARCH, IND_STANDBY, IND_DATA: wave_q <= high_q;
        IND_SLEEP:                         wave_q <= 1'b1;
        IND_CALL:                          wave_q <= 1'b0;
        default:                           wave_q <= 1'b0;
      endcase
    end
  end

endmodule : mpk_blink

// ===== mpk_ctrl.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "mpk_defines.svh"

module mpk_ctrl #(
  parameter int unsigned CYC_PER_MS = `MPK_MS_NS / `MPK_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins, active low
  input  wire logic        power_button_n,
  input  wire logic        reset_req_n,
  // Card detect pin
  input  wire logic        card_detect,
  // Power and reset outputs
  output logic             logic_supply_out,
  output logic             module_reset_out,
  // Indicator pins
  output logic             net_indicator_out,
  output logic             indicator_alt_out,
  output logic             indicator_aux_out,
  // Interrupt
  output logic             irq
);
  import mpk_pkg::*;

  localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `MPK_CTRL_OFS) || (a == `MPK_MODE_OFS) || (a == `MPK_STATUS_OFS) ||
                (a == `MPK_INT_STAT_OFS) || (a == `MPK_INT_CLR_OFS) || (a == `MPK_INT_EN_OFS);
  endfunction : is_mapped

  // Millisecond timebase
  logic [15:0] div_q;
  logic        ms_tick;

  assign ms_tick = (div_q == MS_LAST);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
    end else if (ce) begin
      div_q <= ms_tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Press measurement on both control pins
  logic        btn_fall;
  logic        btn_release;
  logic [15:0] btn_ms;
  logic        rst_fall;
  logic        rst_release;
  logic [15:0] rst_ms;

  mpk_press_timer u_btn_timer (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .ms_tick       (ms_tick),
    .pin_n         (power_button_n),
    .fall_pulse    (btn_fall),
    .release_pulse (btn_release),
    .held_ms_q     (btn_ms)
  );

  mpk_press_timer u_rst_timer (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .ms_tick       (ms_tick),
    .pin_n         (reset_req_n),
    .fall_pulse    (rst_fall),
    .release_pulse (rst_release),
    .held_ms_q     (rst_ms)
  );

  // Bus decode
  logic apb_setup;
  logic apb_write;

  assign pready    = ce;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & ce & is_mapped(paddr);

  // Control registers
  logic          hotplug_en_q;
  logic          polarity_q;
  mpk_route_type route_q;
  mpk_ind_type   mode_q;
  logic [`MPK_EV_W-1:0] int_en_q;
  logic          soft_off_cmd;
  logic          soft_rst_cmd;

  assign soft_off_cmd = apb_write && paddr == `MPK_CTRL_OFS && pwdata[`MPK_CTRL_POWEROFF];
  assign soft_rst_cmd = apb_write && paddr == `MPK_CTRL_OFS && pwdata[`MPK_CTRL_RESET];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hotplug_en_q <= `MPK_HOTPLUG_RST;
      polarity_q   <= `MPK_POLARITY_RST;
      route_q      <= mpk_route_type'(`MPK_ROUTE_RST);
    end else if (apb_write && paddr == `MPK_CTRL_OFS) begin
      hotplug_en_q <= pwdata[`MPK_CTRL_HOTPLUG];
      polarity_q   <= pwdata[`MPK_CTRL_POLARITY];
      route_q      <= mpk_route_type'(pwdata[`MPK_CTRL_ROUTE_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_q <= mpk_ind_type'(`MPK_MODE_RST);
    end else if (apb_write && paddr == `MPK_MODE_OFS) begin
      mode_q <= mpk_ind_type'(pwdata[2:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_en_q <= `MPK_INT_EN_RST;
    end else if (apb_write && paddr == `MPK_INT_EN_OFS) begin
      int_en_q <= pwdata[`MPK_EV_W-1:0];
    end
  end

  // Power sequencer
  mpk_pwr_type pwr_q;
  logic [15:0] st_ms_q;
  logic        soft_off_q;
  logic        btn_armed_q;
  logic        rst_armed_q;
  logic [`MPK_EV_W-1:0] ev;

  // Presses that started before power-on must not end it on release
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      btn_armed_q <= 1'b0;
      rst_armed_q <= 1'b0;
    end else if (ce) begin
      if (pwr_q != PWR_ON) begin
        btn_armed_q <= 1'b0;
        rst_armed_q <= 1'b0;
      end else begin
        if (btn_fall) begin
          btn_armed_q <= 1'b1;
        end
        if (rst_fall) begin
          rst_armed_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_q      <= PWR_OFF;
      st_ms_q    <= 16'h0000;
      soft_off_q <= 1'b0;
    end else if (ce) begin
      unique case (pwr_q)
        PWR_OFF: begin
          st_ms_q <= 16'h0000;
          if (!power_button_n && soft_off_q) begin
            pwr_q      <= PWR_ON;
            soft_off_q <= 1'b0;
          end else if (!power_button_n && btn_ms >= `MPK_ON_PRESS_MS) begin
            pwr_q      <= PWR_ON;
            soft_off_q <= 1'b0;
          end
        end
        PWR_ON: begin
          st_ms_q <= 16'h0000;
          if (btn_release && btn_armed_q && btn_ms >= `MPK_OFF_PRESS_MS) begin
            pwr_q <= PWR_SHUTDOWN;
          end else if (soft_off_cmd) begin
            pwr_q      <= PWR_SHUTDOWN;
            soft_off_q <= 1'b1;
          end else if (rst_release && rst_armed_q && rst_ms >= `MPK_RST_PRESS_MS) begin
            pwr_q <= PWR_RESET;
          end else if (soft_rst_cmd) begin
            pwr_q <= PWR_RESET;
          end
        end
        PWR_SHUTDOWN: begin
          // Supply stays up while the module logs off
          if (ms_tick) begin
            if (st_ms_q + 16'h0001 >= `MPK_SHUTDOWN_MS) begin
              pwr_q   <= PWR_OFF;
              st_ms_q <= 16'h0000;
            end else begin
              st_ms_q <= st_ms_q + 16'h0001;
            end
          end
        end
        PWR_RESET: begin
          if (ms_tick) begin
            if (st_ms_q + 16'h0001 >= `MPK_RESET_HOLD_MS) begin
              pwr_q   <= PWR_ON;
              st_ms_q <= 16'h0000;
            end else begin
              st_ms_q <= st_ms_q + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // Card presence
  logic card_level;
  logic card_q;
  logic card_seen_q;

  assign card_level = (card_detect == polarity_q);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      card_q      <= 1'b0;
      card_seen_q <= 1'b0;
    end else if (ce) begin
      if (pwr_q == PWR_OFF) begin
        card_seen_q <= 1'b0;
      end else if (!card_seen_q) begin
        card_q      <= card_level;
        card_seen_q <= 1'b1;
      end else if (hotplug_en_q) begin
        card_q <= card_level;
      end
    end
  end

  // Events: pulses into sticky status
  logic        card_prev_q;
  mpk_pwr_type pwr_prev_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      card_prev_q <= 1'b0;
      pwr_prev_q  <= PWR_OFF;
    end else if (ce) begin
      card_prev_q <= card_q;
      pwr_prev_q  <= pwr_q;
    end
  end

  always_comb begin
    ev                      = '0;
    ev[`MPK_EV_POWERED_ON]  = (pwr_q == PWR_ON) && (pwr_prev_q == PWR_OFF);
    ev[`MPK_EV_SHUTDOWN]    = (pwr_q == PWR_SHUTDOWN) && (pwr_prev_q != PWR_SHUTDOWN);
    ev[`MPK_EV_POWERED_OFF] = (pwr_q == PWR_OFF) && (pwr_prev_q == PWR_SHUTDOWN);
    ev[`MPK_EV_RESET]       = (pwr_q == PWR_ON) && (pwr_prev_q == PWR_RESET);
    ev[`MPK_EV_CARD_IN]     = card_seen_q && card_q && !card_prev_q && hotplug_en_q;
    ev[`MPK_EV_CARD_OUT]    = card_seen_q && !card_q && card_prev_q && hotplug_en_q;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  logic [`MPK_EV_W-1:0] int_stat_q;
  logic [`MPK_EV_W-1:0] int_clr;

  assign int_clr = (apb_write && paddr == `MPK_INT_CLR_OFS) ? pwdata[`MPK_EV_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_stat_q <= '0;
    end else if (ce) begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((int_stat_q & ~int_clr) | ev) & int_en_q);
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && apb_setup) begin
      pslverr <= ~is_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `MPK_CTRL_OFS: begin
            prdata[`MPK_CTRL_ROUTE_LSB +: 2] <= route_q;
            prdata[`MPK_CTRL_HOTPLUG]        <= hotplug_en_q;
            prdata[`MPK_CTRL_POLARITY]       <= polarity_q;
          end
          `MPK_MODE_OFS: prdata[2:0] <= mode_q;
          `MPK_STATUS_OFS: begin
            prdata[`MPK_STAT_PWR_LSB +: 2]  <= pwr_q;
            prdata[`MPK_STAT_SUPPLY]        <= logic_supply_out;
            prdata[`MPK_STAT_CARD]          <= card_q;
            prdata[`MPK_STAT_SOFTOFF]       <= soft_off_q;
            prdata[`MPK_STAT_HELD_LSB +: 16] <= btn_ms;
          end
          `MPK_INT_STAT_OFS: prdata[`MPK_EV_W-1:0] <= int_stat_q;
          `MPK_INT_EN_OFS:   prdata[`MPK_EV_W-1:0] <= int_en_q;
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Indicator waveform and routing
  logic        wave;
  mpk_ind_type live_mode;

  // Indicator dark whenever the module is not running
  assign live_mode = (pwr_q == PWR_ON) ? mode_q : IND_DARK;

  mpk_blink u_blink (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .ms_tick (ms_tick),
    .mode    (live_mode),
    .wave_q  (wave)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      net_indicator_out <= 1'b0;
      indicator_alt_out <= 1'b0;
      indicator_aux_out <= 1'b0;
    end else if (ce) begin
      net_indicator_out <= wave && (route_q != ROUTE_ALT) && (route_q != ROUTE_AUX);
      indicator_alt_out <= wave && (route_q == ROUTE_ALT);
      indicator_aux_out <= wave && (route_q == ROUTE_AUX);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      logic_supply_out <= 1'b0;
      module_reset_out <= 1'b0;
    end else if (ce) begin
      logic_supply_out <= (pwr_q != PWR_OFF);
      module_reset_out <= (pwr_q == PWR_RESET);
    end
  end

endmodule : mpk_ctrl

// ===== mpk_ctrl_sva.sv
`timescale 1ns/1ps

module mpk_ctrl_sva #(
  parameter int unsigned CYC_PER_MS = 40000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins
  input wire logic power_button_n,
  input wire logic reset_req_n,
  input wire logic logic_supply_out,
  input wire logic module_reset_out,
  input wire logic net_indicator_out,
  input wire logic indicator_alt_out,
  input wire logic indicator_aux_out
);
  logic [31:0] btn_lo_q, req_lo_q, sup_hi_q, mrst_hi_q;
  logic        btn_up_q, req_up_q;
  logic [2:0]  ind;

  assign ind = {indicator_aux_out, indicator_alt_out, net_indicator_out};

  // Press counts start only at a seen fall, so a pin low out of reset is no press
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      btn_up_q <= 1'b0;
      req_up_q <= 1'b0;
      btn_lo_q <= 32'h0;
      req_lo_q <= 32'h0;
    end else begin
      btn_up_q <= power_button_n;
      req_up_q <= reset_req_n;
      btn_lo_q <= (!power_button_n && (btn_up_q || btn_lo_q != 32'h0)) ? btn_lo_q + 32'h1 : 32'h0;
      req_lo_q <= (!reset_req_n && (req_up_q || req_lo_q != 32'h0)) ? req_lo_q + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sup_hi_q  <= 32'h0;
      mrst_hi_q <= 32'h0;
    end else begin
      sup_hi_q  <= logic_supply_out ? sup_hi_q + 32'h1 : 32'h0;
      mrst_hi_q <= module_reset_out ? mrst_hi_q + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_one_pin_only: assert property ($onehot0(ind))
    else $error("more than one indicator pin active");
  a_dark_when_off: assert property (!logic_supply_out |-> ind == 3'b000)
    else $error("indicator active while unpowered");
  a_on_needs_button: assert property ($rose(logic_supply_out) |-> !$past(power_button_n))
    else $error("power came up without button low");
  a_on_after_hold: assert property (btn_lo_q == 1603 * CYC_PER_MS |-> logic_supply_out)
    else $error("no power-on after long button hold");
  a_reset_on_release: assert property ($rose(reset_req_n) && req_lo_q >= 2102 * CYC_PER_MS
    && logic_supply_out && !module_reset_out |-> ##[1:8] module_reset_out)
    else $error("no module reset after reset pin release");
  a_reset_span: assert property ($fell(module_reset_out) |->
    mrst_hi_q inside {[9 * CYC_PER_MS : 11 * CYC_PER_MS]})
    else $error("module reset pulse length wrong");
  a_reset_holds: assert property ($rose(module_reset_out) |=> module_reset_out [*8])
    else $error("module reset pulse too short");
  a_reset_when_on: assert property ($rose(module_reset_out) |-> logic_supply_out)
    else $error("module reset while unpowered");
  a_shutdown_span: assert property ($fell(logic_supply_out) |-> sup_hi_q >= 6000 * CYC_PER_MS)
    else $error("supply dropped before shutdown time");

  c_power_on: cover property ($rose(logic_supply_out));
  c_power_off: cover property ($fell(logic_supply_out));
  c_reset: cover property ($rose(module_reset_out));
endmodule : mpk_ctrl_sva

bind mpk_ctrl mpk_ctrl_sva #(.CYC_PER_MS(CYC_PER_MS)) i_mpk_ctrl_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .power_button_n(power_button_n), .reset_req_n(reset_req_n),
  .logic_supply_out(logic_supply_out), .module_reset_out(module_reset_out),
  .net_indicator_out(net_indicator_out), .indicator_alt_out(indicator_alt_out),
  .indicator_aux_out(indicator_aux_out)
);

// ===== mpk_host.sv
`timescale 1ns/1ps

module mpk_host #(
  parameter int CYC     = 4,
  parameter int BOOT_MS = 2
) (
  // Clock and supply sense
  input  wire logic ref_clk,
  input  wire logic logic_supply_out,
  // Control pins, idle high through pull-ups
  output logic      power_button_n,
  output logic      reset_req_n,
  output logic      card_detect
);
  localparam int ON_MS  = 2000;
  localparam int RST_MS = 3000;
  localparam int OFF_MS = 2200;
  int   up_cyc = 0;
  logic off_q  = 1'b0;

  initial begin
    power_button_n = 1'b1;
    reset_req_n    = 1'b1;
    card_detect    = 1'b1;
  end

  always @(posedge ref_clk) up_cyc <= up_cyc + 1;

  task automatic press(input logic rst_pin, input int ms);
    logic was_on;
    while (up_cyc < 30 * CYC) @(posedge ref_clk);
    while (off_q && logic_supply_out) @(posedge ref_clk);
    @(posedge ref_clk);
    was_on = logic_supply_out;
    off_q = 1'b0;
    if (rst_pin) reset_req_n <= 1'b0;
    else power_button_n <= 1'b0;
    repeat (ms * CYC) @(posedge ref_clk);
    reset_req_n    <= 1'b1;
    power_button_n <= 1'b1;
    off_q = !rst_pin && was_on;
    // Boot time scaled down to keep the run short
    if (!rst_pin && !was_on) repeat (BOOT_MS * CYC) @(posedge ref_clk);
  endtask : press

  task automatic card(input logic v);
    @(posedge ref_clk);
    card_detect <= v;
  endtask : card
endmodule : mpk_host

// ===== tb.sv
`timescale 1ns/1ps
`include "mpk_defines.svh"

module tb;
  import mpk_pkg::*;

  localparam int CYC = 4;
  logic        ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, irq, power_button_n, reset_req_n, card_detect;
  logic        logic_supply_out, module_reset_out;
  logic [2:0]  pins;
  logic [5:0]  obs;
  int          fail_count = 0, num_checks = 0, cyc = 0, n;

  mpk_ctrl #(.CYC_PER_MS(CYC)) i_mpk_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_button_n(power_button_n), .reset_req_n(reset_req_n), .card_detect(card_detect),
    .logic_supply_out(logic_supply_out), .module_reset_out(module_reset_out),
    .net_indicator_out(pins[0]), .indicator_alt_out(pins[1]), .indicator_aux_out(pins[2]), .irq(irq)
  );
  mpk_host #(.CYC(CYC)) i_mpk_host (
    .ref_clk(ref_clk), .logic_supply_out(logic_supply_out), .power_button_n(power_button_n),
    .reset_req_n(reset_req_n), .card_detect(card_detect)
  );

  assign obs = {irq, module_reset_out, logic_supply_out, pins};
  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Ends once pready is high; the bench timeout ends it if pready stays low
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdreg

  // Leaves n as the number of cycles spent waiting
  task automatic await(input int i, input logic v, input int lim);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
  endtask : await

  task automatic blink(input int p, input mpk_ind_type m, input int hi, input int lo);
    apb(1'b1, `MPK_MODE_OFS, {29'h0, m});
    // Mode change restarts high; skip the pipeline glitch, first phase is partial
    repeat (8) @(posedge ref_clk);
    await(p, 1'b0, 14000);
    await(p, 1'b1, 14000);
    check(n, lo * CYC);
    await(p, 1'b0, 14000);
    check(n, hi * CYC);
    check(pins & ~(3'b001 << p), 3'b000);
  endtask : blink

  task automatic t_reset_vals();
    rdreg(`MPK_CTRL_OFS, 32'hff, 32'hc0);
    rdreg(`MPK_STATUS_OFS, 32'h1f, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Enable low stalls the bus and freezes the timebase
    ce <= 1'b0;
    fork
      apb(1'b1, `MPK_MODE_OFS, 32'h4);
      begin
        repeat (6) @(posedge ref_clk);
        check(pready, 1'b0);
        ce <= 1'b1;
      end
    join
    rdreg(`MPK_MODE_OFS, 32'h7, 32'h4);
  endtask : t_reset_vals

  task automatic t_power_on();
    apb(1'b1, `MPK_INT_EN_OFS, 32'h1);
    fork
      i_mpk_host.press(1'b0, i_mpk_host.ON_MS);
      begin
        while (power_button_n) @(posedge ref_clk);
        repeat (1598 * CYC) @(posedge ref_clk);
        check(logic_supply_out, 1'b0);
        await(3, 1'b1, 10 * CYC);
        check(logic_supply_out, 1'b1);
      end
    join
    check(irq, 1'b1);
    rdreg(`MPK_INT_STAT_OFS, 32'h1, 32'h1);
    apb(1'b1, `MPK_INT_CLR_OFS, 32'h3f);
    await(5, 1'b0, 4);
    check(irq, 1'b0);
    rdreg(`MPK_STATUS_OFS, 32'h1f, 32'hd);
  endtask : t_power_on

  task automatic t_indicators();
    blink(0, IND_DATA, 75, 75);
    apb(1'b1, `MPK_CTRL_OFS, 32'hd0);
    blink(1, IND_SEARCH, 600, 600);
    apb(1'b1, `MPK_CTRL_OFS, 32'he0);
    blink(2, IND_STANDBY, 3000, 75);
    apb(1'b1, `MPK_MODE_OFS, {29'h0, IND_CALL});
    repeat (8) @(posedge ref_clk);
    check(pins, 3'b000);
    apb(1'b1, `MPK_MODE_OFS, {29'h0, IND_SLEEP});
    repeat (8) @(posedge ref_clk);
    check(pins, 3'b100);
    apb(1'b1, `MPK_CTRL_OFS, 32'hc0);
  endtask : t_indicators

  task automatic t_card();
    apb(1'b1, `MPK_INT_EN_OFS, 32'h30);
    i_mpk_host.card(1'b0);
    repeat (4) @(posedge ref_clk);
    rdreg(`MPK_STATUS_OFS, 32'h8, 32'h0);
    rdreg(`MPK_INT_STAT_OFS, 32'h30, 32'h20);
    check(irq, 1'b1);
    apb(1'b1, `MPK_INT_CLR_OFS, 32'h3f);
    apb(1'b1, `MPK_CTRL_OFS, 32'h80);
    i_mpk_host.card(1'b1);
    repeat (4) @(posedge ref_clk);
    rdreg(`MPK_STATUS_OFS, 32'h8, 32'h0);
    rdreg(`MPK_INT_STAT_OFS, 32'h30, 32'h0);
    apb(1'b1, `MPK_CTRL_OFS, 32'h40);
    i_mpk_host.card(1'b0);
    repeat (4) @(posedge ref_clk);
    rdreg(`MPK_STATUS_OFS, 32'h8, 32'h8);
    apb(1'b1, `MPK_CTRL_OFS, 32'hc0);
    apb(1'b1, `MPK_INT_EN_OFS, 32'h0);
    apb(1'b1, `MPK_INT_CLR_OFS, 32'h3f);
  endtask : t_card

  task automatic t_resets();
    apb(1'b1, `MPK_CTRL_OFS, 32'hc2);
    await(4, 1'b1, 8);
    check(module_reset_out, 1'b1);
    await(4, 1'b0, 20 * CYC);
    rdreg(`MPK_INT_STAT_OFS, 32'h8, 32'h8);
    check(irq, 1'b0);
    apb(1'b1, `MPK_INT_CLR_OFS, 32'h3f);
    fork
      i_mpk_host.press(1'b1, i_mpk_host.RST_MS);
      begin
        repeat ((i_mpk_host.RST_MS - 1) * CYC) @(posedge ref_clk);
        check(module_reset_out, 1'b0);
      end
    join
    await(4, 1'b1, 8 * CYC);
    check(module_reset_out, 1'b1);
    await(4, 1'b0, 20 * CYC);
    rdreg(`MPK_STATUS_OFS, 32'h7, 32'h5);
  endtask : t_resets

  task automatic t_soft_off();
    apb(1'b1, `MPK_CTRL_OFS, 32'hc1);
    rdreg(`MPK_STATUS_OFS, 32'h7, 32'h6);
    await(3, 1'b0, 6100 * CYC);
    check(n > 5990 * CYC && n <= 6000 * CYC, 1'b1);
    rdreg(`MPK_STATUS_OFS, 32'h17, 32'h10);
    fork
      i_mpk_host.press(1'b0, 10);
      begin
        await(3, 1'b1, 8 * CYC);
        check(logic_supply_out, 1'b1);
      end
    join
  endtask : t_soft_off

  task automatic t_button_off();
    i_mpk_host.press(1'b0, i_mpk_host.OFF_MS);
    repeat (4) @(posedge ref_clk);
    rdreg(`MPK_STATUS_OFS, 32'h7, 32'h6);
  endtask : t_button_off

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_power_on();
    t_indicators();
    t_card();
    t_resets();
    t_soft_off();
    t_button_off();
    conclude();
  end
endmodule : tb
